/* core/cpu_alu_pkg.sv */
// Purpose: Shared constants and types of the CPU ALU and status flag block.
// Assumes: One 25 MHz core clock; 16-bit register bus with 4-bit byte address.
// Notes:   Positions of the status word fields are fixed by the CPU.
package cpu_alu_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          DW          = 16;
  localparam int          AW          = 4;
  localparam logic [3:0]  STATUS_OFS  = 4'h0;
  localparam logic [3:0]  EVENT_OFS   = 4'h4;
  localparam logic [3:0]  MASK_OFS    = 4'h8;
  localparam logic [3:0]  MUL_HI_OFS  = 4'hc;

  // ----------------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------------
  localparam int          C_BIT       = 0;
  localparam int          Z_BIT       = 1;
  localparam int          OV_BIT      = 2;
  localparam int          N_BIT       = 3;
  localparam int          RA_BIT      = 4;
  localparam int          PRIO_LSB    = 5;
  localparam int          PRIO_MSB    = 7;
  localparam int          DC_BIT      = 8;
  localparam logic [2:0]  PRIO_MAX    = 3'h7;

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------
  localparam int          NEV         = 4;
  localparam int          EV_OVF      = 0;
  localparam int          EV_DIV0     = 1;
  localparam int          EV_DIV_DONE = 2;
  localparam int          EV_MUL_DONE = 3;

  // ----------------------------------------------------------------------
  // Datapath constants
  // ----------------------------------------------------------------------
  localparam logic [4:0]  DIV_STEPS   = 5'h10;
  localparam logic [15:0] BYTE_MASK   = 16'h00ff;
  localparam logic [15:0] BYTE_SIGN   = 16'h0080;
  localparam logic [15:0] WORD_SIGN   = 16'h8000;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR,
    OP_SHL, OP_LSR, OP_ASR, OP_MOV, OP_MUL, OP_DIV
  } alu_op_t;

  typedef enum logic [2:0] {
    MUL_SS, MUL_UU, MUL_S_LIT, MUL_U_LIT, MUL_US, MUL_UU8
  } mul_mode_t;

  typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_FIX} div_state_t;

  typedef struct packed {
    alu_op_t     op;
    mul_mode_t   mul_mode;
    logic        byte_mode;
    logic        src_mem;
    logic        dst_mem;
    logic        use_lit;
    logic        div_signed;
    logic        div_long;
    logic [4:0]  lit5;
    logic [15:0] dst_addr;
  } alu_req_t;

  typedef struct packed {
    logic        c, z, ov, n, dc, ra;
    logic [2:0]  prio;
    logic [NEV-1:0] evt;
    logic [NEV-1:0] mask;
    logic [15:0] rd_data;
    logic [15:0] res;
    logic [15:0] res_hi;
    logic        res_valid;
    logic        wreg_we;
    logic        mem_we;
    logic [15:0] dst_addr;
    div_state_t  div_st;
    logic [4:0]  cnt;
    logic [16:0] rem;
    logic [15:0] quo;
    logic [15:0] dvs;
    logic        neg_q;
    logic        neg_r;
  } alu_state_t;

endpackage

/* core/cpu_alu_status_flags.sv */
// Purpose: 16-bit CPU ALU with status flags, multiply front end and divider.
// Assumes: Requests and operands come from decoder logic on core_clk_i.
// Notes:   Byte results are returned zero-extended in the upper byte.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module cpu_alu_status_flags
  import cpu_alu_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire logic           nrst_i,
  input  wire logic [AW-1:0]  bus_addr_i,
  input  wire logic [DW-1:0]  bus_wdata_i,
  input  wire logic           bus_wr_i,
  input  wire logic           bus_rd_i,
  output logic      [DW-1:0]  bus_rdata_o,
  input  wire logic           req_valid_i,
  input  wire alu_req_t       req_i,
  output logic                busy_o,
  input  wire logic [15:0]    wreg_a_i,
  input  wire logic [15:0]    mem_a_i,
  input  wire logic [15:0]    wreg_b_i,
  input  wire logic [15:0]    dividend_hi_i,
  input  wire logic           repeat_active_i,
  input  wire logic           priority_top_bit_i,
  input  wire logic           nesting_disable_i,
  output logic      [15:0]    result_o,
  output logic      [15:0]    result_hi_o,
  output logic                result_valid_o,
  output logic                wreg_we_o,
  output logic                mem_we_o,
  output logic      [15:0]    dst_addr_o,
  output logic      [15:0]    cpu_status_word_o,
  output logic      [3:0]     cpu_priority_o,
  output logic                user_irq_disable_o,
  output logic                irq_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0]  rst_sync_r;
  logic        rst_n;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------------
  // Datapath signals
  // ----------------------------------------------------------------------
  alu_state_t         s_r;
  alu_state_t         s_nxt;
  logic        [15:0] opa;
  logic        [15:0] opb;
  logic        [15:0] am;
  logic        [15:0] bm;
  logic        [15:0] bx;
  logic               is_sub;
  logic               cin;
  logic        [16:0] sum17;
  logic        [4:0]  nib5;
  logic        [8:0]  lo9;
  logic        [15:0] r;
  logic        [15:0] rm;
  logic               msb_a;
  logic               msb_b;
  logic               msb_r;
  logic               zero_r;
  logic signed [16:0] ma;
  logic signed [16:0] mb;
  logic signed [33:0] prod;
  logic        [31:0] dd;
  logic        [31:0] dd_abs;
  logic        [15:0] dv_abs;
  logic               dd_neg;
  logic               dv_neg;
  logic        [16:0] trial;
  logic               ge;
  logic        [15:0] sw;
  logic               accept;

  function automatic logic top_bit(input logic [15:0] x, input logic bm8);
    top_bit = bm8 ? x[7] : x[15];
  endfunction

  // ----------------------------------------------------------------------
  // Operand selection and arithmetic
  // ----------------------------------------------------------------------
  always_comb begin
    opa    = req_i.src_mem ? mem_a_i : wreg_a_i;
    opb    = req_i.use_lit ? {11'h000, req_i.lit5} : wreg_b_i;
    am     = req_i.byte_mode ? (opa & BYTE_MASK) : opa;
    bm     = req_i.byte_mode ? (opb & BYTE_MASK) : opb;
    is_sub = (req_i.op == OP_SUB) || (req_i.op == OP_SUBB);
    // Subtraction adds the inverted operand, so carry means no borrow.
    bx     = is_sub ? (~bm & (req_i.byte_mode ? BYTE_MASK : 16'hffff)) : bm;
    unique case (req_i.op)
      OP_ADDC, OP_SUBB: cin = s_r.c;
      OP_SUB:           cin = 1'b1;
      default:          cin = 1'b0;
    endcase
    sum17 = {1'b0, am} + {1'b0, bx} + {16'h0000, cin};
    nib5  = {1'b0, am[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    lo9   = {1'b0, am[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
    msb_a = top_bit(am, req_i.byte_mode);
    msb_b = top_bit(bx, req_i.byte_mode);
    unique case (req_i.op)
      OP_AND:  r = am & bm;
      OP_OR:   r = am | bm;
      OP_XOR:  r = am ^ bm;
      OP_SHL:  r = {am[14:0], 1'b0};
      OP_LSR:  r = {1'b0, am[15:1]};
      OP_ASR:  r = {1'b0, am[15:1]}
                   | (msb_a ? (req_i.byte_mode ? BYTE_SIGN : WORD_SIGN) : 16'h0000);
      OP_MOV:  r = am;
      default: r = sum17[15:0];
    endcase
    rm     = req_i.byte_mode ? (r & BYTE_MASK) : r;
    msb_r  = top_bit(rm, req_i.byte_mode);
    zero_r = (rm == 16'h0000);
  end

  // ----------------------------------------------------------------------
  // Shared 17x17 multiplier
  // ----------------------------------------------------------------------
  always_comb begin
    // Unsigned operands zero-extend into bit 16, signed ones sign-extend.
    unique case (req_i.mul_mode)
      MUL_SS: begin
        ma = {opa[15], opa};
        mb = {wreg_b_i[15], wreg_b_i};
      end
      MUL_S_LIT: begin
        ma = {opa[15], opa};
        mb = {12'h000, req_i.lit5};
      end
      MUL_U_LIT: begin
        ma = {1'b0, opa};
        mb = {12'h000, req_i.lit5};
      end
      MUL_US: begin
        ma = {1'b0, opa};
        mb = {wreg_b_i[15], wreg_b_i};
      end
      MUL_UU8: begin
        ma = {9'h000, opa[7:0]};
        mb = {9'h000, wreg_b_i[7:0]};
      end
      default: begin
        ma = {1'b0, opa};
        mb = {1'b0, wreg_b_i};
      end
    endcase
    prod = ma * mb;
  end

  // ----------------------------------------------------------------------
  // Divider operand preparation
  // ----------------------------------------------------------------------
  always_comb begin
    if (req_i.div_long) begin
      dd = {dividend_hi_i, opa};
    end else if (req_i.div_signed) begin
      dd = {{16{opa[15]}}, opa};
    end else begin
      dd = {16'h0000, opa};
    end
    dd_neg = req_i.div_signed & dd[31];
    dv_neg = req_i.div_signed & wreg_b_i[15];
    dd_abs = dd_neg ? (32'h0 - dd) : dd;
    dv_abs = dv_neg ? (16'h0 - wreg_b_i) : wreg_b_i;
    trial  = {s_r.rem[15:0], s_r.quo[15]};
    ge     = (trial >= {1'b0, s_r.dvs});
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  assign accept = req_valid_i && (s_r.div_st == DIV_IDLE);

  always_comb begin
    s_nxt           = s_r;
    s_nxt.rd_data   = 16'h0000;
    s_nxt.res_valid = 1'b0;
    s_nxt.wreg_we   = 1'b0;
    s_nxt.mem_we    = 1'b0;
    s_nxt.ra        = repeat_active_i;

    // Register writes; an ALU update in the same cycle takes precedence.
    if (bus_wr_i) begin
      unique case (bus_addr_i)
        STATUS_OFS: begin
          s_nxt.c  = bus_wdata_i[C_BIT];
          s_nxt.z  = bus_wdata_i[Z_BIT];
          s_nxt.ov = bus_wdata_i[OV_BIT];
          s_nxt.n  = bus_wdata_i[N_BIT];
          s_nxt.dc = bus_wdata_i[DC_BIT];
          if (!nesting_disable_i) begin
            s_nxt.prio = bus_wdata_i[PRIO_MSB:PRIO_LSB];
          end
        end
        EVENT_OFS: s_nxt.evt  = s_r.evt & ~bus_wdata_i[NEV-1:0];
        MASK_OFS:  s_nxt.mask = bus_wdata_i[NEV-1:0];
        default:   s_nxt.mask = s_r.mask;
      endcase
    end

    if (bus_rd_i) begin
      unique case (bus_addr_i)
        STATUS_OFS: s_nxt.rd_data = sw;
        EVENT_OFS:  s_nxt.rd_data = {{(DW-NEV){1'b0}}, s_r.evt};
        MASK_OFS:   s_nxt.rd_data = {{(DW-NEV){1'b0}}, s_r.mask};
        MUL_HI_OFS: s_nxt.rd_data = s_r.res_hi;
        default:    s_nxt.rd_data = 16'h0000;
      endcase
    end

    // Single-cycle operations.
    if (accept && (req_i.op != OP_DIV)) begin
      s_nxt.res_valid = 1'b1;
      s_nxt.wreg_we   = !req_i.dst_mem;
      s_nxt.mem_we    = req_i.dst_mem;
      s_nxt.dst_addr  = req_i.dst_addr;
      if (req_i.op == OP_MUL) begin
        // Multiply leaves every flag alone.
        s_nxt.res           = prod[15:0];
        s_nxt.res_hi        = prod[31:16];
        s_nxt.evt[EV_MUL_DONE] = 1'b1;
      end else begin
        s_nxt.res = rm;
        s_nxt.n   = msb_r;
        unique case (req_i.op)
          OP_ADD, OP_SUB, OP_ADDC, OP_SUBB: begin
            s_nxt.c  = req_i.byte_mode ? sum17[8] : sum17[16];
            s_nxt.dc = req_i.byte_mode ? nib5[4] : lo9[8];
            s_nxt.ov = (msb_a == msb_b) && (msb_r != msb_a);
            s_nxt.evt[EV_OVF] = s_nxt.evt[EV_OVF] | s_nxt.ov;
          end
          OP_SHL: s_nxt.c = msb_a;
          OP_LSR, OP_ASR: s_nxt.c = am[0];
          default: s_nxt.c = s_r.c;
        endcase
        // Carry-chained ops keep a clear zero flag so multiword zero tests work.
        if ((req_i.op == OP_ADDC) || (req_i.op == OP_SUBB)) begin
          s_nxt.z = s_r.z & zero_r;
        end else begin
          s_nxt.z = zero_r;
        end
      end
    end

    // Restoring divider, one cycle per divisor bit.
    unique case (s_r.div_st)
      DIV_IDLE: begin
        if (accept && (req_i.op == OP_DIV)) begin
          s_nxt.dst_addr = req_i.dst_addr;
          if (wreg_b_i == 16'h0000) begin
            s_nxt.evt[EV_DIV0] = 1'b1;
            s_nxt.res          = 16'h0000;
            s_nxt.res_hi       = 16'h0000;
            s_nxt.res_valid    = 1'b1;
            s_nxt.wreg_we      = 1'b1;
          end else begin
            s_nxt.div_st = DIV_RUN;
            s_nxt.cnt    = DIV_STEPS;
            s_nxt.rem    = {1'b0, dd_abs[31:16]};
            s_nxt.quo    = dd_abs[15:0];
            s_nxt.dvs    = dv_abs;
            s_nxt.neg_q  = dd_neg ^ dv_neg;
            s_nxt.neg_r  = dd_neg;
          end
        end
      end
      DIV_RUN: begin
        s_nxt.rem = ge ? (trial - {1'b0, s_r.dvs}) : trial;
        s_nxt.quo = {s_r.quo[14:0], ge};
        s_nxt.cnt = s_r.cnt - 5'h01;
        if (s_r.cnt == 5'h01) begin
          s_nxt.div_st = DIV_FIX;
        end
      end
      DIV_FIX: begin
        s_nxt.res              = s_r.neg_q ? (16'h0 - s_r.quo) : s_r.quo;
        s_nxt.res_hi           = s_r.neg_r ? (16'h0 - s_r.rem[15:0]) : s_r.rem[15:0];
        s_nxt.res_valid        = 1'b1;
        s_nxt.wreg_we          = 1'b1;
        s_nxt.evt[EV_DIV_DONE] = 1'b1;
        s_nxt.div_st           = DIV_IDLE;
      end
      default: s_nxt.div_st = DIV_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // All-zero reset gives status word, mask and events their reset values.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    sw              = 16'h0000;
    sw[C_BIT]       = s_r.c;
    sw[Z_BIT]       = s_r.z;
    sw[OV_BIT]      = s_r.ov;
    sw[N_BIT]       = s_r.n;
    sw[RA_BIT]      = s_r.ra;
    sw[DC_BIT]      = s_r.dc;
    sw[PRIO_MSB:PRIO_LSB] = s_r.prio;
  end

  assign cpu_status_word_o  = sw;
  assign cpu_priority_o     = {priority_top_bit_i, s_r.prio};
  assign user_irq_disable_o = priority_top_bit_i || (s_r.prio == PRIO_MAX);
  assign bus_rdata_o        = s_r.rd_data;
  assign busy_o             = (s_r.div_st != DIV_IDLE);
  assign result_o           = s_r.res;
  assign result_hi_o        = s_r.res_hi;
  assign result_valid_o     = s_r.res_valid;
  assign wreg_we_o          = s_r.wreg_we;
  assign mem_we_o           = s_r.mem_we;
  assign dst_addr_o         = s_r.dst_addr;
  assign irq_o              = |(s_r.evt & s_r.mask);

endmodule // cpu_alu_status_flags

/* verification/cpu_alu_status_flags_assertions.sv */
// Purpose: Port-level checks of the ALU and status flag block.
// Assumes: One core clock; requests start three edges after reset release.
// Notes:   Checks wait out the reset synchroniser.
`timescale 1ns/1ps

module cpu_alu_status_flags_assertions
  import cpu_alu_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire logic           nrst_i,
  input  wire logic [AW-1:0]  bus_addr_i,
  input  wire logic           bus_wr_i,
  input  wire logic           req_valid_i,
  input  wire alu_req_t       req_i,
  input  wire logic           busy_o,
  input  wire logic [15:0]    wreg_b_i,
  input  wire logic           repeat_active_i,
  input  wire logic           priority_top_bit_i,
  input  wire logic           nesting_disable_i,
  input  wire logic [15:0]    result_o,
  input  wire logic           result_valid_o,
  input  wire logic           wreg_we_o,
  input  wire logic           mem_we_o,
  input  wire logic [15:0]    dst_addr_o,
  input  wire logic [15:0]    cpu_status_word_o,
  input  wire logic [3:0]     cpu_priority_o,
  input  wire logic           user_irq_disable_o
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic [1:0] up_r;
  logic       go;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end

  assign go = req_valid_i && !busy_o;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i || up_r != 2'h3);

  sequence s_div_run;
    busy_o [*8] ##10 (result_valid_o && !busy_o);
  endsequence

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_irq_block_level: assert property (
    user_irq_disable_o == (priority_top_bit_i || cpu_status_word_o[7:5] == PRIO_MAX))
    else $error("user interrupt disable does not follow priority");
  a_prio_concat: assert property (
    cpu_priority_o == {priority_top_bit_i, cpu_status_word_o[7:5]})
    else $error("priority level is not top bit over status field");
  a_prio_locked: assert property (
    nesting_disable_i && bus_wr_i && bus_addr_i == STATUS_OFS
    |=> $stable(cpu_status_word_o[7:5]))
    else $error("priority field changed while nesting disabled");
  a_repeat_mirror: assert property (
    1'b1 |=> cpu_status_word_o[RA_BIT] == $past(repeat_active_i))
    else $error("repeat bit does not follow repeat loop");
  a_neg_sign: assert property (
    go && !req_i.byte_mode && req_i.op inside {OP_ADD, OP_SUB, OP_AND, OP_ASR}
    |=> result_valid_o && cpu_status_word_o[N_BIT] == result_o[15])
    else $error("negative flag differs from result sign");
  a_zero_result: assert property (
    go && req_i.op inside {OP_ADD, OP_SUB, OP_XOR, OP_LSR}
    |=> cpu_status_word_o[Z_BIT] == (result_o == 16'h0000))
    else $error("zero flag differs from result");
  a_mul_keeps_flags: assert property (
    go && req_i.op == OP_MUL && !bus_wr_i
    |=> {cpu_status_word_o[8], cpu_status_word_o[3:0]}
        == $past({cpu_status_word_o[8], cpu_status_word_o[3:0]}))
    else $error("multiply changed a flag");
  a_div_latency: assert property (
    go && req_i.op == OP_DIV && wreg_b_i != 16'h0000 |=> s_div_run)
    else $error("divide did not finish on time");
  a_dest_memory: assert property (
    go && req_i.op != OP_DIV && req_i.dst_mem
    |=> mem_we_o && !wreg_we_o && dst_addr_o == $past(req_i.dst_addr))
    else $error("memory write-back missing");
endmodule // cpu_alu_status_flags_assertions

bind cpu_alu_status_flags cpu_alu_status_flags_assertions i_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_addr_i(bus_addr_i),
  .bus_wr_i(bus_wr_i), .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o),
  .wreg_b_i(wreg_b_i), .repeat_active_i(repeat_active_i),
  .priority_top_bit_i(priority_top_bit_i), .nesting_disable_i(nesting_disable_i),
  .result_o(result_o), .result_valid_o(result_valid_o), .wreg_we_o(wreg_we_o),
  .mem_we_o(mem_we_o), .dst_addr_o(dst_addr_o), .cpu_status_word_o(cpu_status_word_o),
  .cpu_priority_o(cpu_priority_o), .user_irq_disable_o(user_irq_disable_o));

/* verification/cpu_alu_status_flags_tb.sv */
// Purpose: Self-checking bench for the ALU and status flag block.
// Assumes: 25 MHz core clock; write-back lands in cpu_writeback_model.
// Notes:   Expected results and flags are worked out by hand.
`timescale 1ns/1ps

module cpu_alu_status_flags_tb
  import cpu_alu_pkg::*;
;
  typedef struct packed {alu_op_t op; logic bm; logic [15:0] a, b, res, fl;} vec_t;
  typedef struct packed {mul_mode_t m; logic [4:0] l; logic [15:0] b, lo, hi;} mvec_t;

  logic        core_clk_i, nrst_i, bus_wr_i, bus_rd_i, req_valid_i, busy_o;
  logic        repeat_active_i, priority_top_bit_i, nesting_disable_i;
  logic        result_valid_o, wreg_we_o, mem_we_o, user_irq_disable_o, irq_o;
  logic [3:0]  bus_addr_i, cpu_priority_o;
  logic [15:0] bus_wdata_i, bus_rdata_o, wreg_a_i, mem_a_i, wreg_b_i, dividend_hi_i;
  logic [15:0] result_o, result_hi_o, dst_addr_o, cpu_status_word_o, rd;
  alu_req_t    req_i, r;
  int          n_fail, n_checks, lat;

  vec_t  tbl [16] = '{
    '{OP_ADD, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 16'h010c},
    '{OP_ADD, 1'b0, 16'hffff, 16'h0001, 16'h0000, 16'h0103},
    '{OP_SUB, 1'b0, 16'h0005, 16'h0007, 16'hfffe, 16'h0008},
    '{OP_SUB, 1'b0, 16'h0007, 16'h0005, 16'h0002, 16'h0101},
    '{OP_ADD, 1'b1, 16'h0008, 16'h0008, 16'h0010, 16'h0100},
    '{OP_ADD, 1'b1, 16'h1280, 16'h3480, 16'h0000, 16'h0007},
    '{OP_AND, 1'b0, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'h0005},
    '{OP_XOR, 1'b0, 16'h5555, 16'h5555, 16'h0000, 16'h0007},
    '{OP_ADDC, 1'b0, 16'hffff, 16'h0000, 16'h0000, 16'h0103},
    '{OP_SUBB, 1'b0, 16'h0003, 16'h0001, 16'h0002, 16'h0101},
    '{OP_OR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 16'h0109},
    '{OP_SHL, 1'b0, 16'h8001, 16'h0000, 16'h0002, 16'h0101},
    '{OP_LSR, 1'b0, 16'h0001, 16'h0000, 16'h0000, 16'h0103},
    '{OP_ASR, 1'b0, 16'h8000, 16'h0000, 16'hc000, 16'h0108},
    '{OP_SUB, 1'b1, 16'h0010, 16'h0001, 16'h000f, 16'h0001},
    '{OP_MOV, 1'b1, 16'h12f0, 16'h0000, 16'h00f0, 16'h0009}};
  mvec_t mtbl [6] = '{
    '{MUL_SS, 5'h00, 16'h0002, 16'hfffe, 16'hffff},
    '{MUL_UU, 5'h00, 16'h0002, 16'hfffe, 16'h0001},
    '{MUL_S_LIT, 5'h1f, 16'h0002, 16'hffe1, 16'hffff},
    '{MUL_U_LIT, 5'h1f, 16'h0002, 16'hffe1, 16'h001e},
    '{MUL_US, 5'h00, 16'hfffe, 16'h0002, 16'hfffe},
    '{MUL_UU8, 5'h00, 16'h00ff, 16'hfe01, 16'h0000}};

  cpu_alu_status_flags i_dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o),
    .wreg_a_i(wreg_a_i), .mem_a_i(mem_a_i), .wreg_b_i(wreg_b_i),
    .dividend_hi_i(dividend_hi_i), .repeat_active_i(repeat_active_i),
    .priority_top_bit_i(priority_top_bit_i), .nesting_disable_i(nesting_disable_i),
    .result_o(result_o), .result_hi_o(result_hi_o), .result_valid_o(result_valid_o),
    .wreg_we_o(wreg_we_o), .mem_we_o(mem_we_o), .dst_addr_o(dst_addr_o),
    .cpu_status_word_o(cpu_status_word_o), .cpu_priority_o(cpu_priority_o),
    .user_irq_disable_o(user_irq_disable_o), .irq_o(irq_o));

  cpu_writeback_model i_far (
    .core_clk_i(core_clk_i), .wreg_we_i(wreg_we_o), .mem_we_i(mem_we_o),
    .addr_i(dst_addr_o), .data_i(result_o));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge core_clk_i);
    bus_wr_i <= 1'b0;
  endtask

  task automatic rdb(input logic [3:0] a);
    @(posedge core_clk_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge core_clk_i);
    bus_rd_i <= 1'b0;
    #1;
    rd = bus_rdata_o;
  endtask

  task automatic issue(input alu_req_t q, input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_i <= q;
    wreg_a_i <= q.src_mem ? ~a : a;
    mem_a_i <= q.src_mem ? a : ~a;
    wreg_b_i <= b;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
  endtask

  // Bounded wait for the result pulse.
  task automatic waitv();
    lat = 0;
    #1;
    while (result_valid_o !== 1'b1 && lat < 40) begin
      @(posedge core_clk_i);
      #1;
      lat++;
    end
    if (lat == 40) begin
      n_fail++;
      summarize();
    end
  endtask

  function automatic alu_req_t mk(input alu_op_t o, input logic bm);
    alu_req_t q;
    q = '0;
    q.op = o;
    q.byte_mode = bm;
    q.dst_addr = 16'h0003;
    return q;
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    nrst_i = 1'b0;
    {bus_wr_i, bus_rd_i, req_valid_i, repeat_active_i} = '0;
    {priority_top_bit_i, nesting_disable_i, req_i} = '0;
    {bus_addr_i, bus_wdata_i, wreg_a_i, mem_a_i, wreg_b_i, dividend_hi_i} = '0;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < 16; i += 2) begin
      rdb(4'(i));
      chk(rd, 16'h0000);
    end
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      wr(STATUS_OFS, 16'(p) << 5);
      priority_top_bit_i <= p == 3;
      rdb(STATUS_OFS);
      chk(rd & 16'h00e0, 16'(p) << 5);
      chk(16'(cpu_priority_o), 16'({p == 3, p[2:0]}));
      chk(16'(user_irq_disable_o), 16'(p == 3 || p == 7));
    end
    nesting_disable_i <= 1'b1;
    wr(STATUS_OFS, 16'h0070);
    rdb(STATUS_OFS);
    chk(rd & 16'h00f0, 16'h00e0);
    nesting_disable_i <= 1'b0;
    priority_top_bit_i <= 1'b0;
    repeat_active_i <= 1'b1;
    wr(STATUS_OFS, 16'h0000);
    rdb(STATUS_OFS);
    chk(rd & 16'h00f0, 16'h0010);
    repeat_active_i <= 1'b0;
    rdb(STATUS_OFS);
    chk(rd & 16'h0010, 16'h0000);
    $display("test status word done");
    for (int i = 0; i < 16; i++) begin
      issue(mk(tbl[i].op, tbl[i].bm), tbl[i].a, tbl[i].b);
      waitv();
      chk(result_o, tbl[i].res);
      chk(cpu_status_word_o & 16'h010f, tbl[i].fl);
    end
    r = mk(OP_ADD, 1'b0);
    r.src_mem = 1'b1;
    r.dst_mem = 1'b1;
    r.dst_addr = 16'h0005;
    issue(r, 16'h0100, 16'h0001);
    waitv();
    chk(result_o, 16'h0101);
    @(posedge core_clk_i);
    #1;
    chk(i_far.mem_r[5], 16'h0101);
    $display("test arithmetic done");
    for (int i = 0; i < 6; i++) begin
      r = mk(OP_MUL, 1'b0);
      r.mul_mode = mtbl[i].m;
      r.lit5 = mtbl[i].l;
      r.use_lit = (mtbl[i].m == MUL_S_LIT || mtbl[i].m == MUL_U_LIT);
      issue(r, 16'hffff, mtbl[i].b);
      waitv();
      chk(result_o, mtbl[i].lo);
      chk(result_hi_o, mtbl[i].hi);
    end
    $display("test multiply done");
    r = mk(OP_DIV, 1'b0);
    r.div_signed = 1'b1;
    issue(r, 16'hfff9, 16'h0002);
    waitv();
    chk(16'(lat), 16'h0011);
    chk(result_o, 16'hfffd);
    chk(result_hi_o, 16'hffff);
    rdb(MUL_HI_OFS);
    chk(rd, 16'hffff);
    r.div_signed = 1'b0;
    r.div_long = 1'b1;
    dividend_hi_i <= 16'h0001;
    issue(r, 16'h0000, 16'h0003);
    // Refused while busy.
    issue(mk(OP_ADD, 1'b0), 16'h0000, 16'h0003);
    waitv();
    chk(16'(lat), 16'h000f);
    chk(result_o, 16'h5555);
    chk(result_hi_o, 16'h0001);
    r.div_long = 1'b0;
    issue(r, 16'h1234, 16'h0000);
    waitv();
    chk(16'(lat), 16'h0000);
    chk(result_o, 16'h0000);
    $display("test divide done");
    rdb(EVENT_OFS);
    chk(rd, 16'h000f);
    chk(16'(irq_o), 16'h0000);
    wr(MASK_OFS, 16'h0002);
    #1;
    chk(16'(irq_o), 16'h0001);
    wr(EVENT_OFS, 16'h0002);
    rdb(EVENT_OFS);
    chk(rd, 16'h000d);
    chk(16'(irq_o), 16'h0000);
    $display("test interrupt done");
    summarize();
  end
endmodule // cpu_alu_status_flags_tb

/* verification/cpu_writeback_model.sv */
// Purpose: Register array and data memory that take the ALU write-back.
// Assumes: Write strobes are one-cycle pulses on the core clock.
// Notes:   Four address bits keep the model small.
`timescale 1ns/1ps

module cpu_writeback_model (
  input  wire logic        core_clk_i,
  input  wire logic        wreg_we_i,
  input  wire logic        mem_we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] data_i
);
  logic [15:0] wreg_r [16];
  logic [15:0] mem_r  [16];

  always_ff @(posedge core_clk_i) begin
    if (wreg_we_i) begin
      wreg_r[addr_i[3:0]] <= data_i;
    end
    if (mem_we_i) begin
      mem_r[addr_i[3:0]] <= data_i;
    end
  end
endmodule // cpu_writeback_model
